/* pra_pkg.sv */
// Notes on behaviour
// - Direction bit 15: 1 adds, 0 subtracts rate
// - One direction bit serves both adjust modes
// - Bit 14 runs temporary adjust for duration
// - Clearing bit 14 stops temporary adjust
// - 30-bit rate split high 13:0, low word
// - Same rate steps continuous and temporary adjust
// - 32-bit duration in 25MHz cycles, two halves
// - Profile bit 7 inert without bit 6
// - Profile mode: all to host, headers untouched
// - Bit 6 classifies, may rewrite, timestamps
// - Bit 6 runs clock, timestamp tail tag
// - Bit 5 Ethernet detection, default on
// - Bit 4 IPv4/UDP detection, default on
// - Bit 3 IPv6/UDP detection, default on
// - Bit 2 peer-to-peer else end-to-end
// - Bit 1 host master else slave
// - Bit 0 one-step else two-step, default one
// - Control bit 2 enables continuous adjust
// - 40ns periods, five 8ns phases, 5-7 invalid
package pra_pkg;
    // Register offsets
    localparam logic [15:0] CLK_CTRL_OFS    = 16'h0500;
    localparam logic [15:0] RATE_HI_OFS     = 16'h050c;
    localparam logic [15:0] RATE_LO_OFS     = 16'h050e;
    localparam logic [15:0] DUR_HI_OFS      = 16'h0510;
    localparam logic [15:0] DUR_LO_OFS      = 16'h0512;
    localparam logic [15:0] MSG_CFG1_OFS    = 16'h0514;
    localparam logic [15:0] ADJ_STATUS_OFS  = 16'h0540;
    // Field positions
    localparam int RATE_DIR_BIT   = 15;
    localparam int TEMP_ADJ_BIT   = 14;
    localparam int RATE_HI_MSB    = 13;
    localparam int CTRL_CONT_BIT  = 2;
    localparam int CTRL_EN_BIT    = 1;
    localparam int CFG_PROFILE_BIT = 7;
    localparam int CFG_PTP_BIT    = 6;
    localparam int CFG_ETH_BIT    = 5;
    localparam int CFG_IPV4_BIT   = 4;
    localparam int CFG_IPV6_BIT   = 3;
    localparam int CFG_P2P_BIT    = 2;
    localparam int CFG_MASTER_BIT = 1;
    localparam int CFG_ONESTEP_BIT = 0;
    localparam int CFG_WIDTH      = 8;
    // Reset values
    localparam logic [15:0] RATE_HI_RST  = 16'h0000;
    localparam logic [15:0] RATE_LO_RST  = 16'h0000;
    localparam logic [15:0] DUR_RST      = 16'h0000;
    localparam logic [7:0]  MSG_CFG1_RST = 8'h39;
    localparam logic [2:0]  CLK_CTRL_RST = 3'h0;
    // Timing: system clock and time-protocol tick
    localparam int SYS_CLK_PERIOD_NS = 20;
    localparam int RTC_PERIOD_NS     = 40;
    localparam int TICK_DIV          = RTC_PERIOD_NS / SYS_CLK_PERIOD_NS;
    localparam int PHASE_NS          = 8;
    localparam int PHASE_COUNT       = RTC_PERIOD_NS / PHASE_NS;
    localparam logic [31:0] NS_PER_SEC = 32'h3b9a_ca00;

    // Temporary adjust sequencer
    typedef enum logic [0:0] {
        TADJ_IDLE = 1'b0,
        TADJ_RUN  = 1'b1
    } pra_tadj_state_t;

    // Message handling controls toward the forwarding fabric
    typedef struct packed {
        logic ptp_enable;
        logic classify_en;
        logic hdr_modify_en;
        logic ts_insert_en;
        logic fwd_all_host;
        logic tail_tag_ts;
        logic det_eth;
        logic det_ipv4;
        logic det_ipv6;
        logic p2p_mode;
        logic host_master;
        logic one_step;
    } pra_msg_ctl_t;

    // Precision time snapshot
    typedef struct packed {
        logic [31:0] sec;
        logic [31:0] ns;
        logic [29:0] sub_ns;
        logic [2:0]  phase;
    } pra_time_t;
endpackage

/* pra_tick_gen.sv */
`timescale 1ns/1ps
module pra_tick_gen
    import pra_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    output logic      tick
);
    localparam logic [1:0] DIV_LAST = 2'(TICK_DIV - 1);
    logic [1:0] div_reg;

    // Divide system clock to the 25MHz enable
    always_ff @(posedge clk) begin
        if (rst) begin
            div_reg <= 2'h0;
        end else if (div_reg == DIV_LAST) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_reg + 2'h1;
        end
    end

    assign tick = (div_reg == DIV_LAST);

    property p_tick_single;
        @(posedge clk) disable iff (rst) tick |=> !tick;
    endproperty
    a_tick_single: assert property (p_tick_single) else $error("tick held two cycles");
endmodule

/* pra_rtc.sv */
`timescale 1ns/1ps
module pra_rtc
    import pra_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        run,
    input  wire logic        tick,
    input  wire logic        apply,
    input  wire logic        add_dir,
    input  wire logic [29:0] rate,
    output pra_time_t        now
);
    localparam logic [5:0] OFS_LAST = 6'(RTC_PERIOD_NS - 1);
    localparam logic [31:0] PERIOD_NS32 = 32'(RTC_PERIOD_NS);
    logic [29:0] frac_reg;
    logic [31:0] ns_reg;
    logic [31:0] sec_reg;
    logic [5:0]  ofs_reg;
    logic [30:0] frac_sum;
    logic        carry;
    logic        borrow;
    logic [31:0] ns_next;

    // Fraction step; carry or borrow moves whole nanoseconds
    always_comb begin
        frac_sum = add_dir ? ({1'b0, frac_reg} + {1'b0, rate})
                           : ({1'b0, frac_reg} - {1'b0, rate});
        carry  = apply && add_dir && frac_sum[30];
        borrow = apply && !add_dir && frac_sum[30];
        ns_next = ns_reg + PERIOD_NS32 + {31'h0, carry} - {31'h0, borrow};
    end

    // Sub-nanosecond accumulator
    always_ff @(posedge clk) begin
        if (rst) begin
            frac_reg <= 30'h0;
        end else if (run && tick && apply) begin
            frac_reg <= frac_sum[29:0];
        end
    end

    // Nanosecond and second counters
    always_ff @(posedge clk) begin
        if (rst) begin
            ns_reg  <= 32'h0;
            sec_reg <= 32'h0;
        end else if (run && tick) begin
            if (ns_next >= NS_PER_SEC) begin
                ns_reg  <= ns_next - NS_PER_SEC;
                sec_reg <= sec_reg + 32'h1;
            end else begin
                ns_reg <= ns_next;
            end
        end
    end

    // Offset inside the 40ns period, nudged by each whole-ns step
    always_ff @(posedge clk) begin
        if (rst) begin
            ofs_reg <= 6'h0;
        end else if (run && tick && carry) begin
            ofs_reg <= (ofs_reg == OFS_LAST) ? 6'h0 : ofs_reg + 6'h1;
        end else if (run && tick && borrow) begin
            ofs_reg <= (ofs_reg == 6'h0) ? OFS_LAST : ofs_reg - 6'h1;
        end
    end

    assign now.sec    = sec_reg;
    assign now.ns     = ns_reg;
    assign now.sub_ns = frac_reg;
    assign now.phase  = 3'(ofs_reg / 6'(PHASE_NS));

    property p_phase_valid;
        @(posedge clk) disable iff (rst) now.phase < 3'(PHASE_COUNT);
    endproperty
    a_phase_valid: assert property (p_phase_valid) else $error("phase code invalid");

    property p_rate_add;
        @(posedge clk) disable iff (rst)
            (run && tick && apply && add_dir) |=> frac_reg == 30'($past(frac_reg) + $past(rate));
    endproperty
    a_rate_add: assert property (p_rate_add) else $error("rate not added");

    property p_rate_sub;
        @(posedge clk) disable iff (rst)
            (run && tick && apply && !add_dir) |=> frac_reg == 30'($past(frac_reg) - $past(rate));
    endproperty
    a_rate_sub: assert property (p_rate_sub) else $error("rate not subtracted");
endmodule

/* pra_top.sv */
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module pra_top
    import pra_pkg::*;
(
    // Clock and reset
    input  wire logic        MCLK_IN,
    input  wire logic        SYS_RST_IN,
    // Register port
    input  wire logic [15:0] ADDR_IN,
    input  wire logic [15:0] WDATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    output logic      [15:0] RDATA_OUT,
    // Message handling controls
    output pra_msg_ctl_t     MSG_CTL_OUT,
    // Precision clock
    output pra_time_t        TIME_OUT,
    output logic             ADJ_ACTIVE_OUT
);
    logic                 clk;
    logic                 rst;
    logic                 tick;
    // Software-visible state
    logic                 rate_dir_reg;
    logic                 temp_bit_reg;
    logic [RATE_HI_MSB:0] rate_hi_reg;
    logic [15:0]          rate_lo_reg;
    logic [15:0]          dur_hi_reg;
    logic [15:0]          dur_lo_reg;
    logic [CFG_WIDTH-1:0] cfg_reg;
    logic [2:0]           ctrl_reg;
    logic [15:0]          rdata_reg;
    // Temporary adjust sequencer
    pra_tadj_state_t      tadj_state_reg;
    pra_tadj_state_t      tadj_state_next;
    logic [31:0]          tadj_cnt_reg;
    logic [31:0]          tadj_cnt_next;
    logic                 tadj_done;
    // Decodes
    logic                 wr_rate_hi;
    logic                 wr_rate_lo;
    logic                 wr_dur_hi;
    logic                 wr_dur_lo;
    logic                 wr_cfg;
    logic                 wr_ctrl;
    logic                 temp_start;
    logic                 temp_stop;
    logic                 ptp_on;
    logic                 profile_on;
    logic                 cont_on;
    logic                 rtc_run;
    logic                 apply;
    logic [29:0]          rate;
    logic [15:0]          status;
    logic [15:0]          rdata_next;

    assign clk = MCLK_IN;
    assign rst = SYS_RST_IN;

    // Time-protocol 25MHz enable
    pra_tick_gen u_tick (
        .clk  (clk),
        .rst  (rst),
        .tick (tick)
    );

    // Write decodes; bus shares our clock so no synchroniser
    always_comb begin
        wr_rate_hi = WR_IN && (ADDR_IN == RATE_HI_OFS);
        wr_rate_lo = WR_IN && (ADDR_IN == RATE_LO_OFS);
        wr_dur_hi  = WR_IN && (ADDR_IN == DUR_HI_OFS);
        wr_dur_lo  = WR_IN && (ADDR_IN == DUR_LO_OFS);
        wr_cfg     = WR_IN && (ADDR_IN == MSG_CFG1_OFS);
        wr_ctrl    = WR_IN && (ADDR_IN == CLK_CTRL_OFS);
        temp_start = wr_rate_hi && WDATA_IN[TEMP_ADJ_BIT];
        temp_stop  = wr_rate_hi && !WDATA_IN[TEMP_ADJ_BIT];
    end

    // Rate word and direction, high half
    always_ff @(posedge clk) begin
        if (rst) begin
            rate_dir_reg <= RATE_HI_RST[RATE_DIR_BIT];
            rate_hi_reg  <= RATE_HI_RST[RATE_HI_MSB:0];
        end else if (wr_rate_hi) begin
            rate_dir_reg <= WDATA_IN[RATE_DIR_BIT];
            rate_hi_reg  <= WDATA_IN[RATE_HI_MSB:0];
        end
    end

    // Rate word, low half
    always_ff @(posedge clk) begin
        if (rst) begin
            rate_lo_reg <= RATE_LO_RST;
        end else if (wr_rate_lo) begin
            rate_lo_reg <= WDATA_IN;
        end
    end

    assign rate = {rate_hi_reg, rate_lo_reg};

    // Duration halves; counted in 25MHz ticks
    always_ff @(posedge clk) begin
        if (rst) begin
            dur_hi_reg <= DUR_RST;
            dur_lo_reg <= DUR_RST;
        end else begin
            if (wr_dur_hi) begin
                dur_hi_reg <= WDATA_IN;
            end
            if (wr_dur_lo) begin
                dur_lo_reg <= WDATA_IN;
            end
        end
    end

    // Message configuration; upper byte reserved, reads zero
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_reg <= MSG_CFG1_RST;
        end else if (wr_cfg) begin
            cfg_reg <= WDATA_IN[CFG_WIDTH-1:0];
        end
    end

    // Clock control: enable and continuous adjust
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= CLK_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_reg <= WDATA_IN[2:0];
        end
    end

    // Sequencer next state; a fresh software write wins over expiry
    always_comb begin
        tadj_state_next = tadj_state_reg;
        tadj_cnt_next   = tadj_cnt_reg;
        tadj_done       = 1'b0;
        case (tadj_state_reg)
            TADJ_IDLE: begin
                if (temp_start) begin
                    tadj_state_next = TADJ_RUN;
                    tadj_cnt_next   = {dur_hi_reg, dur_lo_reg};
                end
            end
            TADJ_RUN: begin
                if (temp_stop) begin
                    tadj_state_next = TADJ_IDLE;
                    tadj_cnt_next   = 32'h0;
                end else if (temp_start) begin
                    tadj_cnt_next = {dur_hi_reg, dur_lo_reg};
                end else if (tick) begin
                    if (tadj_cnt_reg <= 32'h1) begin
                        tadj_state_next = TADJ_IDLE;
                        tadj_cnt_next   = 32'h0;
                        tadj_done       = 1'b1;
                    end else begin
                        tadj_cnt_next = tadj_cnt_reg - 32'h1;
                    end
                end
            end
            default: begin
                tadj_state_next = TADJ_IDLE;
                tadj_cnt_next   = 32'h0;
            end
        endcase
    end

    // Sequencer state
    always_ff @(posedge clk) begin
        if (rst) begin
            tadj_state_reg <= TADJ_IDLE;
            tadj_cnt_reg   <= 32'h0;
        end else begin
            tadj_state_reg <= tadj_state_next;
            tadj_cnt_reg   <= tadj_cnt_next;
        end
    end

    // Mode bit: software write, else hardware clears at expiry
    always_ff @(posedge clk) begin
        if (rst) begin
            temp_bit_reg <= RATE_HI_RST[TEMP_ADJ_BIT];
        end else if (wr_rate_hi) begin
            temp_bit_reg <= WDATA_IN[TEMP_ADJ_BIT];
        end else if (tadj_done) begin
            temp_bit_reg <= 1'b0;
        end
    end

    // Rate applies when either adjust mode is live
    always_comb begin
        ptp_on     = cfg_reg[CFG_PTP_BIT];
        profile_on = ptp_on && cfg_reg[CFG_PROFILE_BIT];
        cont_on    = ctrl_reg[CTRL_CONT_BIT];
        rtc_run    = ptp_on || ctrl_reg[CTRL_EN_BIT];
        apply      = cont_on || (tadj_state_reg == TADJ_RUN);
    end

    // Precision clock
    pra_rtc u_rtc (
        .clk     (clk),
        .rst     (rst),
        .run     (rtc_run),
        .tick    (tick),
        .apply   (apply),
        .add_dir (rate_dir_reg),
        .rate    (rate),
        .now     (TIME_OUT)
    );

    // Fabric controls; profile mode forbids header edits
    always_comb begin
        MSG_CTL_OUT.ptp_enable    = ptp_on;
        MSG_CTL_OUT.classify_en   = ptp_on;
        MSG_CTL_OUT.hdr_modify_en = ptp_on && !profile_on;
        MSG_CTL_OUT.ts_insert_en  = ptp_on && !profile_on;
        MSG_CTL_OUT.fwd_all_host  = profile_on;
        MSG_CTL_OUT.tail_tag_ts   = ptp_on;
        MSG_CTL_OUT.det_eth       = cfg_reg[CFG_ETH_BIT];
        MSG_CTL_OUT.det_ipv4      = cfg_reg[CFG_IPV4_BIT];
        MSG_CTL_OUT.det_ipv6      = cfg_reg[CFG_IPV6_BIT];
        MSG_CTL_OUT.p2p_mode      = cfg_reg[CFG_P2P_BIT];
        MSG_CTL_OUT.host_master   = cfg_reg[CFG_MASTER_BIT];
        MSG_CTL_OUT.one_step      = cfg_reg[CFG_ONESTEP_BIT];
    end

    assign ADJ_ACTIVE_OUT = apply && rtc_run;

    // Status word: live sequencer and clock state
    assign status = {13'h0, rtc_run, cont_on, (tadj_state_reg == TADJ_RUN)};

    // Read mux; unmapped addresses read zero
    always_comb begin
        case (ADDR_IN)
            RATE_HI_OFS:    rdata_next = {rate_dir_reg, temp_bit_reg, rate_hi_reg};
            RATE_LO_OFS:    rdata_next = rate_lo_reg;
            DUR_HI_OFS:     rdata_next = dur_hi_reg;
            DUR_LO_OFS:     rdata_next = dur_lo_reg;
            MSG_CFG1_OFS:   rdata_next = {8'h00, cfg_reg};
            CLK_CTRL_OFS:   rdata_next = {13'h0, ctrl_reg};
            ADJ_STATUS_OFS: rdata_next = status;
            default:        rdata_next = 16'h0000;
        endcase
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= 16'h0000;
        end else if (RD_IN) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    assign RDATA_OUT = rdata_reg;

    property p_temp_start;
        @(posedge clk) disable iff (rst)
            temp_start |=> (tadj_state_reg == TADJ_RUN)
                && (tadj_cnt_reg == {$past(dur_hi_reg), $past(dur_lo_reg)});
    endproperty
    a_temp_start: assert property (p_temp_start) else $error("temp adjust not started");

    property p_temp_stop;
        @(posedge clk) disable iff (rst)
            temp_stop |=> (tadj_state_reg == TADJ_IDLE) && !temp_bit_reg && (apply == cont_on);
    endproperty
    a_temp_stop: assert property (p_temp_stop) else $error("temp adjust not stopped");

    property p_temp_expire;
        @(posedge clk) disable iff (rst)
            (tadj_state_reg == TADJ_RUN && tick && tadj_cnt_reg == 32'h1 && !WR_IN)
                |=> (tadj_state_reg == TADJ_IDLE) && !temp_bit_reg;
    endproperty
    a_temp_expire: assert property (p_temp_expire) else $error("expiry missed");

    property p_temp_count;
        @(posedge clk) disable iff (rst)
            (tadj_state_reg == TADJ_RUN && tick && tadj_cnt_reg > 32'h1 && !WR_IN)
                |=> tadj_cnt_reg == $past(tadj_cnt_reg) - 32'h1;
    endproperty
    a_temp_count: assert property (p_temp_count) else $error("count not decremented");

    property p_cont_apply;
        @(posedge clk) disable iff (rst) cont_on |-> apply;
    endproperty
    a_cont_apply: assert property (p_cont_apply) else $error("continuous rate not applied");

    property p_profile_gate;
        @(posedge clk) disable iff (rst)
            !cfg_reg[CFG_PTP_BIT] |-> !MSG_CTL_OUT.fwd_all_host && !MSG_CTL_OUT.hdr_modify_en;
    endproperty
    a_profile_gate: assert property (p_profile_gate) else $error("profile active without ptp");

    property p_profile_hdr;
        @(posedge clk) disable iff (rst)
            MSG_CTL_OUT.fwd_all_host |-> !MSG_CTL_OUT.hdr_modify_en && !MSG_CTL_OUT.ts_insert_en;
    endproperty
    a_profile_hdr: assert property (p_profile_hdr) else $error("header edit in profile mode");

    property p_cfg_reset;
        @(posedge clk) $fell(rst) |-> MSG_CTL_OUT.det_eth && MSG_CTL_OUT.det_ipv4
            && MSG_CTL_OUT.det_ipv6 && MSG_CTL_OUT.one_step && !MSG_CTL_OUT.p2p_mode
            && !MSG_CTL_OUT.host_master;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("config defaults wrong");

    property p_read_data;
        @(posedge clk) disable iff (rst)
            (RD_IN && ADDR_IN == RATE_LO_OFS && !WR_IN) |=> RDATA_OUT == $past(rate_lo_reg);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data mismatch");

    // Register writes land as written, tied to the bus not the flops
    property p_dir_write;
        @(posedge clk) disable iff (rst)
            wr_rate_hi |=> rate_dir_reg == $past(WDATA_IN[RATE_DIR_BIT]);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction not written");

    property p_rate_write;
        @(posedge clk) disable iff (rst)
            wr_rate_lo |=> rate[15:0] == $past(WDATA_IN);
    endproperty
    a_rate_write: assert property (p_rate_write) else $error("rate low not written");

    property p_dur_write;
        @(posedge clk) disable iff (rst)
            wr_dur_hi |=> dur_hi_reg == $past(WDATA_IN);
    endproperty
    a_dur_write: assert property (p_dur_write) else $error("duration not written");

    property p_ptp_write;
        @(posedge clk) disable iff (rst)
            wr_cfg |=> MSG_CTL_OUT.ptp_enable == $past(WDATA_IN[CFG_PTP_BIT])
                && MSG_CTL_OUT.tail_tag_ts == $past(WDATA_IN[CFG_PTP_BIT]);
    endproperty
    a_ptp_write: assert property (p_ptp_write) else $error("mode bit not applied");

    property p_det_write;
        @(posedge clk) disable iff (rst)
            wr_cfg |=> MSG_CTL_OUT.det_eth == $past(WDATA_IN[CFG_ETH_BIT])
                && MSG_CTL_OUT.det_ipv4 == $past(WDATA_IN[CFG_IPV4_BIT])
                && MSG_CTL_OUT.det_ipv6 == $past(WDATA_IN[CFG_IPV6_BIT]);
    endproperty
    a_det_write: assert property (p_det_write) else $error("detection not applied");

    property p_role_write;
        @(posedge clk) disable iff (rst)
            wr_cfg |=> MSG_CTL_OUT.p2p_mode == $past(WDATA_IN[CFG_P2P_BIT])
                && MSG_CTL_OUT.host_master == $past(WDATA_IN[CFG_MASTER_BIT])
                && MSG_CTL_OUT.one_step == $past(WDATA_IN[CFG_ONESTEP_BIT]);
    endproperty
    a_role_write: assert property (p_role_write) else $error("clock role not applied");
endmodule

/* ptp_clock_rate_adjust_msg_config_tb.sv */
`timescale 1ns/1ps
module ptp_clock_rate_adjust_msg_config_tb;
    import pra_pkg::*;
    // Bench signals
    logic         mclk, rst, wr, rd, adj_active;
    logic [15:0]  addr, wdata, rdata, q;
    pra_msg_ctl_t msg_ctl;
    pra_time_t    now;
    int           err_total, n_compared, tk, n;
    logic [29:0]  rate;
    logic [7:0]   cfg;
    logic [15:0]  v;
    longint       dlt, one;

    pra_top DUT (
        .MCLK_IN        (mclk),
        .SYS_RST_IN     (rst),
        .ADDR_IN        (addr),
        .WDATA_IN       (wdata),
        .WR_IN          (wr),
        .RD_IN          (rd),
        .RDATA_OUT      (rdata),
        .MSG_CTL_OUT    (msg_ctl),
        .TIME_OUT       (now),
        .ADJ_ACTIVE_OUT (adj_active)
    );

    // 50 MHz clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One-cycle write strobe
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Expected controls toward the fabric
    function automatic pra_msg_ctl_t exp_ctl(input logic [7:0] c);
        pra_msg_ctl_t e;
        e.ptp_enable    = c[6];
        e.classify_en   = c[6];
        e.hdr_modify_en = c[6] & ~c[7];
        e.ts_insert_en  = c[6] & ~c[7];
        e.fwd_all_host  = c[6] & c[7];
        e.tail_tag_ts   = c[6];
        e.det_eth       = c[5];
        e.det_ipv4      = c[4];
        e.det_ipv6      = c[3];
        e.p2p_mode      = c[2];
        e.host_master   = c[1];
        e.one_step      = c[0];
        return e;
    endfunction

    // Time as one count of 2^-30 ns units; seconds never reached in this run
    function automatic longint tot(input pra_time_t t);
        return longint'({2'b00, t.ns, t.sub_ns});
    endfunction

    // Counts ticks over a window and the total time moved
    task automatic span(input int cyc, output longint d, output int t);
        pra_time_t p;
        longint    s;
        #1;
        p = now;
        s = tot(now);
        t = 0;
        repeat (cyc) begin
            @(posedge mclk);
            #1;
            if (now !== p) t++;
            p = now;
        end
        d = tot(now) - s;
    endtask

    // Stray hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        print_verdict();
    end

    initial begin
        one = longint'(40) <<< 30;
        err_total = 0;
        n_compared = 0;
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 16'h0000;
        wdata = 16'h0000;
        v = 16'($urandom(47273));
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        // Reset state of registers and outputs
        rd_reg(RATE_HI_OFS, q); chk(q, 16'h0000);
        rd_reg(RATE_LO_OFS, q); chk(q, 16'h0000);
        rd_reg(DUR_HI_OFS, q); chk(q, 16'h0000);
        rd_reg(DUR_LO_OFS, q); chk(q, 16'h0000);
        rd_reg(MSG_CFG1_OFS, q); chk(q, 16'h0039);
        @(posedge mclk);
        #1;
        chk(rdata, 16'h0000);
        chk(msg_ctl, exp_ctl(8'h39));
        chk(adj_active, 1'b0);
        // Clock idle while neither enable is set
        span(10, dlt, tk); chk(dlt, 0);
        // Plain halves read back, unmapped place stays empty
        for (int i = 0; i < 4; i++) begin
            v = 16'($urandom);
            wr_reg(RATE_LO_OFS, v); rd_reg(RATE_LO_OFS, q); chk(q, v);
            v = 16'($urandom);
            wr_reg(DUR_HI_OFS, v); rd_reg(DUR_HI_OFS, q); chk(q, v);
            v = 16'($urandom);
            wr_reg(DUR_LO_OFS, v); rd_reg(DUR_LO_OFS, q); chk(q, v);
        end
        wr_reg(16'h0600, 16'hffff);
        rd_reg(16'h0600, q); chk(q, 16'h0000);
        // Config corners first, then random bytes with junk above bit 7
        for (int i = 0; i < 14; i++) begin
            case (i)
                0: cfg = 8'h80;
                1: cfg = 8'hc0;
                2: cfg = 8'h40;
                3: cfg = 8'h00;
                4: cfg = 8'hff;
                5: cfg = 8'hbf;
                default: cfg = 8'($urandom);
            endcase
            wr_reg(MSG_CFG1_OFS, {8'($urandom), cfg});
            rd_reg(MSG_CFG1_OFS, q); chk(q, {8'h00, cfg});
            chk(msg_ctl, exp_ctl(cfg));
        end
        // Mode bit alone runs the clock at one step per 40 ns
        wr_reg(MSG_CFG1_OFS, 16'h0040);
        span(10, dlt, tk); chk(tk, 5);
        chk(dlt, longint'(tk) * one);
        wr_reg(MSG_CFG1_OFS, 16'h0039);
        // Continuous adjust in both directions
        for (int dir = 0; dir < 2; dir++) begin
            rate = 30'($urandom);
            wr_reg(RATE_LO_OFS, rate[15:0]);
            wr_reg(RATE_HI_OFS, {dir[0], 1'b0, rate[29:16]});
            wr_reg(CLK_CTRL_OFS, 16'h0006);
            span(20, dlt, tk);
            chk(adj_active, 1'b1);
            rd_reg(ADJ_STATUS_OFS, q); chk(q, 16'h0006);
            rd_reg(CLK_CTRL_OFS, q); chk(q, 16'h0006);
            chk(now.phase, (now.ns % 40) / 8);
            chk(dlt - longint'(tk) * one, (dir ? 1 : -1) * longint'(tk) * rate);
            wr_reg(CLK_CTRL_OFS, 16'h0002);
        end
        // Temporary adjust runs for the duration, then clears itself
        for (int i = 0; i < 6; i++) begin
            n = (i % 3 == 0) ? 0 : ((i % 3 == 1) ? 1 : 3);
            rate = 30'($urandom);
            wr_reg(DUR_HI_OFS, 16'h0000);
            wr_reg(DUR_LO_OFS, 16'(n));
            wr_reg(RATE_LO_OFS, rate[15:0]);
            wr_reg(RATE_HI_OFS, {i[0], 1'b1, rate[29:16]});
            span(30, dlt, tk);
            if (n == 0) n = 1;
            chk(dlt - longint'(tk) * one, (i[0] ? 1 : -1) * longint'(n) * rate);
            chk(adj_active, 1'b0);
            rd_reg(RATE_HI_OFS, q); chk(q, {i[0], 1'b0, rate[29:16]});
        end
        // Clearing the mode bit cuts a long run short
        rate = 30'($urandom);
        wr_reg(DUR_LO_OFS, 16'h03e8);
        wr_reg(RATE_HI_OFS, {1'b1, 1'b1, rate[29:16]});
        repeat (5) @(posedge mclk);
        #1;
        chk(adj_active, 1'b1);
        rd_reg(ADJ_STATUS_OFS, q); chk(q, 16'h0005);
        wr_reg(RATE_HI_OFS, {1'b1, 1'b1, rate[29:16]});
        wr_reg(RATE_HI_OFS, {1'b1, 1'b0, rate[29:16]});
        span(12, dlt, tk);
        chk(dlt, longint'(tk) * one);
        chk(adj_active, 1'b0);
        // Second reset in mid-run restores defaults
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd_reg(MSG_CFG1_OFS, q); chk(q, 16'h0039);
        rd_reg(RATE_HI_OFS, q); chk(q, 16'h0000);
        chk({now.sec, now.ns}, 64'h0);
        chk({now.sub_ns, now.phase}, 64'h0);
        print_verdict();
    end
endmodule
